// File: include/cfsp_cfg.svh
`ifndef CFSP_CFG_SVH
`define CFSP_CFG_SVH
// Register byte offsets on the APB.
`define CFSP_OFF_WORD_LO   8'h00
`define CFSP_OFF_WORD_HI   8'h04
`define CFSP_OFF_CTRL      8'h08
`define CFSP_OFF_STATUS    8'h0c
// Configuration word bit positions.
`define CFSP_BIT_CASC_DIS  2
`define CFSP_BIT_VERIFY_DIS 3
`define CFSP_BIT_LOCKOUT   4
`define CFSP_BIT_CLK_POL   38
`define CFSP_BIT_PORTB_EN  63
// Control register bit positions.
`define CFSP_CTRL_GATE     0
`define CFSP_CTRL_DEBUG    1
`define CFSP_CTRL_RELOAD   2
// Reset values and sizes.
`define CFSP_WORD_RESET    64'h0000000000000000
`define CFSP_WORD_BYTES    4'h8
`define CFSP_BLOCK_BYTES   2048
`define CFSP_BLOCKS        2
`endif

// File: include/cfsp_pkg.sv
package cfsp_pkg;
	localparam int CFSP_AW = 12;
	// One SRAM port request.
	typedef struct packed {
		logic              we;
		logic [CFSP_AW-1:0] addr;
		logic [7:0]        wdata;
	} cfsp_sram_req_t;
	// Processor request, with routing to port B for debug.
	typedef struct packed {
		logic              to_portb;
		cfsp_sram_req_t    req;
	} cfsp_cpu_req_t;
	// Loader states.
	typedef enum logic [1:0] {
		CFSP_IDLE,
		CFSP_LOAD,
		CFSP_DONE,
		CFSP_LOCK
	} cfsp_state_t;
endpackage

// File: hdl/cfsp_top.sv
// The implementer's own choices: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`include "cfsp_cfg.svh"
module cfsp_top
	import cfsp_pkg::*;
(
	input  wire logic           pclk,
	input  wire logic           presetn,
	input  wire logic           psel,
	input  wire logic           penable,
	input  wire logic           pwrite,
	input  wire logic [7:0]     paddr,
	input  wire logic [31:0]    pwdata,
	output logic                pready,
	output logic [31:0]         prdata,
	output logic                pslverr,
	input  wire logic           cfg_mode_pin_low,
	input  wire logic           cfg_mode_pin_high,
	input  wire logic           nv_byte_valid,
	input  wire logic [7:0]     nv_byte,
	output logic                init_pin,
	output logic                cfg_done_pin,
	output logic                check_pin_oe,
	output logic                cascade_select_out,
	output logic                cascade_select_oe,
	output logic                sram_port_clock_polarity,
	input  wire cfsp_cpu_req_t  cpu_req,
	output logic [7:0]          cpu_rdata,
	input  wire logic           fpga_clk,
	input  wire cfsp_sram_req_t fpga_req,
	output logic [7:0]          fpga_rdata
);
	localparam int DEPTH = `CFSP_BLOCK_BYTES * `CFSP_BLOCKS;

	logic [63:0]    sys_config_word_ff, nxt_sys_config_word;
	logic           fpga_access_gate_ff, debug_self_modify_mode_ff;
	logic           rdy_ff;
	logic [31:0]    prdata_ff;
	cfsp_state_t    state_ff, nxt_state;
	logic [3:0]     byte_cnt_ff;
	logic [2:0]     pwrup_ff;
	logic [1:0]     mode_s1_ff, mode_s2_ff;
	logic           nvv_s1_ff, nvv_s2_ff, nvv_s3_ff;
	logic [7:0]     nvb_s1_ff, nvb_s2_ff;
	logic           fck_s1_ff, fck_s2_ff, fck_s3_ff;
	cfsp_sram_req_t freq_s1_ff, freq_s2_ff;
	logic [7:0]     mem [DEPTH];
	logic [7:0]     cpu_rdata_ff, fpga_rdata_ff;

	// Bus decode.
	wire acc      = psel & penable;
	wire done_acc = acc & rdy_ff;
	wire sel_lo   = paddr == `CFSP_OFF_WORD_LO;
	wire sel_hi   = paddr == `CFSP_OFF_WORD_HI;
	wire sel_ctrl = paddr == `CFSP_OFF_CTRL;
	wire sel_stat = paddr == `CFSP_OFF_STATUS;
	wire mapped   = sel_lo | sel_hi | sel_ctrl | sel_stat;
	wire wr       = done_acc & pwrite & mapped;
	wire lockout  = sys_config_word_ff[`CFSP_BIT_LOCKOUT];
	wire loading  = state_ff == CFSP_LOAD;
	wire word_wr_ok = !lockout && !loading;

	// Mode pins and loader strobes.
	wire mode_reserved = mode_s2_ff[1];
	wire nv_take  = loading & nvv_s2_ff & !nvv_s3_ff;
	wire reload   = wr & sel_ctrl & pwdata[`CFSP_CTRL_RELOAD];
	// The power-up request waits two edges so that the mode pins have crossed the synchroniser first.
	wire start    = (pwrup_ff[2] | reload) & !mode_reserved & (state_ff != CFSP_LOCK);

	// Port B enable and debug routing.
	wire portb_en = sys_config_word_ff[`CFSP_BIT_PORTB_EN] & !loading & !fpga_access_gate_ff;
	wire dbg_b    = debug_self_modify_mode_ff & cpu_req.to_portb;
	wire fck_edge = sys_config_word_ff[`CFSP_BIT_CLK_POL] ? (fck_s3_ff & !fck_s2_ff)
	                                                      : (!fck_s3_ff & fck_s2_ff);
	wire a_wr     = cpu_req.req.we & !dbg_b;
	wire b_wr     = dbg_b ? cpu_req.req.we : (portb_en & fck_edge & freq_s2_ff.we);
	wire [CFSP_AW-1:0] b_addr  = dbg_b ? cpu_req.req.addr : freq_s2_ff.addr;
	wire [7:0]         b_wdata = dbg_b ? cpu_req.req.wdata : freq_s2_ff.wdata;

	// Status register view.
	wire [31:0] status_w = {25'h0, portb_en, mode_s2_ff, mode_reserved, lockout,
	                        state_ff == CFSP_DONE, loading};
	wire [31:0] ctrl_w   = {30'h0, debug_self_modify_mode_ff, fpga_access_gate_ff};
	wire [31:0] rd_mux   = sel_lo ? sys_config_word_ff[31:0] : sel_hi ? sys_config_word_ff[63:32]
	                     : sel_ctrl ? ctrl_w : sel_stat ? status_w : 32'h0;

	assign pready  = rdy_ff;
	assign prdata  = prdata_ff;
	assign pslverr = done_acc & !mapped;

	// APB answer: one wait state, read data captured before pready.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rdy_ff    <= 1'b0;
			prdata_ff <= 32'h0;
		end else begin
			rdy_ff    <= acc & !rdy_ff;
			if (acc && !rdy_ff && !pwrite) begin
				prdata_ff <= rd_mux;
			end
		end
	end

	// Word update from the loader or from software.
	always_comb begin
		nxt_sys_config_word = sys_config_word_ff;
		if (nv_take) begin
			nxt_sys_config_word[8*byte_cnt_ff[2:0] +: 8] = nvb_s2_ff;
		end else if (wr && sel_lo && word_wr_ok) begin
			nxt_sys_config_word[31:0] = pwdata;
		end else if (wr && sel_hi && word_wr_ok) begin
			nxt_sys_config_word[63:32] = pwdata;
		end
	end

	// Configuration word and software control bits; reset clears all.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sys_config_word_ff        <= `CFSP_WORD_RESET;
			fpga_access_gate_ff       <= 1'b0;
			debug_self_modify_mode_ff <= 1'b0;
		end else begin
			sys_config_word_ff <= nxt_sys_config_word;
			if (wr && sel_ctrl) begin
				fpga_access_gate_ff       <= pwdata[`CFSP_CTRL_GATE];
				debug_self_modify_mode_ff <= pwdata[`CFSP_CTRL_DEBUG];
			end
		end
	end

	// Loader sequencing; lockout is checked only when a download starts.
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			CFSP_IDLE, CFSP_DONE: begin
				if (start) begin
					nxt_state = lockout ? CFSP_LOCK : CFSP_LOAD;
				end
			end
			CFSP_LOAD: begin
				if (nv_take && byte_cnt_ff == `CFSP_WORD_BYTES - 4'h1) begin
					nxt_state = CFSP_DONE;
				end
			end
			CFSP_LOCK: nxt_state = CFSP_LOCK;
			default:   nxt_state = CFSP_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_ff    <= CFSP_IDLE;
			byte_cnt_ff <= 4'h0;
			pwrup_ff    <= 3'h1;
		end else begin
			state_ff    <= nxt_state;
			byte_cnt_ff <= !loading ? 4'h0 : byte_cnt_ff + {3'h0, nv_take};
			pwrup_ff    <= {pwrup_ff[1:0], 1'b0};
		end
	end

	// Pin synchronisers; the first stage feeds only the second.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_s1_ff <= 2'h0;
			mode_s2_ff <= 2'h0;
			nvv_s1_ff  <= 1'b0;
			nvv_s2_ff  <= 1'b0;
			nvv_s3_ff  <= 1'b0;
			nvb_s1_ff  <= 8'h0;
			nvb_s2_ff  <= 8'h0;
			fck_s1_ff  <= 1'b0;
			fck_s2_ff  <= 1'b0;
			fck_s3_ff  <= 1'b0;
			freq_s1_ff <= '0;
			freq_s2_ff <= '0;
		end else begin
			mode_s1_ff <= {cfg_mode_pin_high, cfg_mode_pin_low};
			mode_s2_ff <= mode_s1_ff;
			nvv_s1_ff  <= nv_byte_valid;
			nvv_s2_ff  <= nvv_s1_ff;
			nvv_s3_ff  <= nvv_s2_ff;
			nvb_s1_ff  <= nv_byte;
			nvb_s2_ff  <= nvb_s1_ff;
			fck_s1_ff  <= fpga_clk;
			fck_s2_ff  <= fck_s1_ff;
			fck_s3_ff  <= fck_s2_ff;
			freq_s1_ff <= fpga_req;
			freq_s2_ff <= freq_s1_ff;
		end
	end

	// Configuration pins.
	assign init_pin           = state_ff == CFSP_LOCK;
	assign cfg_done_pin       = state_ff == CFSP_DONE;
	assign check_pin_oe       = loading & !sys_config_word_ff[`CFSP_BIT_VERIFY_DIS];
	assign cascade_select_oe  = loading & !sys_config_word_ff[`CFSP_BIT_CASC_DIS];
	assign cascade_select_out = 1'b0;
	assign sram_port_clock_polarity = sys_config_word_ff[`CFSP_BIT_CLK_POL];

	// Shared memory: one byte per entry, consecutive 2 Kbyte blocks; port A wins a same-address write.
	for (genvar i = 0; i < DEPTH; i++) begin : g_mem
		always_ff @(posedge pclk) begin
			if (a_wr && cpu_req.req.addr == CFSP_AW'(i)) begin
				mem[i] <= cpu_req.req.wdata;
			end else if (b_wr && b_addr == CFSP_AW'(i)) begin
				mem[i] <= b_wdata;
			end
		end
	end

	// Read data of port A every cycle, and of port B only while portb_en is high, zero otherwise; no read strobe.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cpu_rdata_ff  <= 8'h0;
			fpga_rdata_ff <= 8'h0;
		end else begin
			cpu_rdata_ff  <= mem[cpu_req.req.addr];
			fpga_rdata_ff <= portb_en ? mem[freq_s2_ff.addr] : 8'h0;
		end
	end
	assign cpu_rdata  = cpu_rdata_ff;
	assign fpga_rdata = fpga_rdata_ff;

	// Checks on the block's own behaviour.
	sequence lock_start_s;
		start && lockout && state_ff != CFSP_LOAD;
	endsequence

	portb_needs_en_a: assert property (@(posedge pclk) disable iff (!presetn)
		portb_en |-> sys_config_word_ff[`CFSP_BIT_PORTB_EN])
		else $error("port B enabled without enable bit");
	portb_off_dl_a: assert property (@(posedge pclk) disable iff (!presetn)
		loading |-> !portb_en)
		else $error("port B enabled during download");
	portb_rd_a: assert property (@(posedge pclk) disable iff (!presetn)
		(portb_en && !b_wr && !a_wr) |=> fpga_rdata == $past(mem[freq_s2_ff.addr]))
		else $error("port B read data wrong");
	gate_block_a: assert property (@(posedge pclk) disable iff (!presetn)
		fpga_access_gate_ff |-> !portb_en)
		else $error("gate did not block port B");
	lockout_seq_a: assert property (@(posedge pclk) disable iff (!presetn)
		lock_start_s |=> (init_pin && !cfg_done_pin)[*3])
		else $error("lockout did not stop download");
	load_done_a: assert property (@(posedge pclk) disable iff (!presetn)
		(nv_take && byte_cnt_ff == 4'h7) |=> cfg_done_pin && !init_pin)
		else $error("download did not complete");
	word_lock_a: assert property (@(posedge pclk) disable iff (!presetn)
		(lockout && !loading) |=> sys_config_word_ff == $past(sys_config_word_ff))
		else $error("locked word changed");
	reserved_mode_a: assert property (@(posedge pclk) disable iff (!presetn)
		(mode_reserved && (state_ff == CFSP_IDLE || state_ff == CFSP_DONE)) |=> !loading)
		else $error("download in reserved mode");
	check_pin_a: assert property (@(posedge pclk) disable iff (!presetn)
		sys_config_word_ff[`CFSP_BIT_VERIFY_DIS] |-> !check_pin_oe)
		else $error("check pin not released");
	cascade_pin_a: assert property (@(posedge pclk) disable iff (!presetn)
		sys_config_word_ff[`CFSP_BIT_CASC_DIS] |-> !cascade_select_oe)
		else $error("cascade pin used while disabled");
	portb_wr_ign_a: assert property (@(posedge pclk) disable iff (!presetn)
		(!portb_en && !dbg_b) |-> !b_wr)
		else $error("write through disabled port B");

	// The power-up download starts once, two edges after reset, unless the synchronised mode is reserved at that moment.
	sequence pwrup_go_s;
		pwrup_ff[2] && !mode_reserved;
	endsequence

	pwrup_load_a: assert property (@(posedge pclk) disable iff (!presetn)
		pwrup_go_s |=> loading)
		else $error("power-up download did not start");
	porta_wr_a: assert property (@(posedge pclk) disable iff (!presetn)
		a_wr |=> mem[$past(cpu_req.req.addr)] == $past(cpu_req.req.wdata))
		else $error("port A write lost");
	dbg_route_a: assert property (@(posedge pclk) disable iff (!presetn)
		(dbg_b && cpu_req.req.we) |-> (b_wr && !a_wr && b_addr == cpu_req.req.addr))
		else $error("debug access missed port B");
	check_pin_own_a: assert property (@(posedge pclk) disable iff (!presetn)
		(loading && !sys_config_word_ff[`CFSP_BIT_VERIFY_DIS]) |-> check_pin_oe)
		else $error("check pin not taken during download");
	lock_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		init_pin |=> init_pin && !cfg_done_pin && !loading)
		else $error("activity after lockout");
	done_stand_a: assert property (@(posedge pclk) disable iff (!presetn)
		(cfg_done_pin && !start) |=> cfg_done_pin)
		else $error("done dropped without a new download");
endmodule

// File: bench/cfsp_partner.sv
`timescale 1ns/1ps
module cfsp_partner
	import cfsp_pkg::*;
(
	input  wire logic      pclk,
	output logic           nv_byte_valid,
	output logic [7:0]     nv_byte,
	output logic           fpga_clk,
	output cfsp_sram_req_t fpga_req
);
	// Idle levels; the FPGA clock stands still outside its own transfers.
	initial begin
		nv_byte_valid = 1'b0;
		nv_byte = 8'h00;
		fpga_clk = 1'b0;
		fpga_req = '0;
	end
	// Streams the word low byte first, each byte steady well around its strobe.
	task automatic load(input logic [63:0] w);
		for (int i = 0; i < 8; i++) begin
			nv_byte <= w[8*i +: 8];
			repeat (4) @(posedge pclk);
			nv_byte_valid <= 1'b1;
			repeat (4) @(posedge pclk);
			nv_byte_valid <= 1'b0;
			repeat (4) @(posedge pclk);
			nv_byte <= ~w[8*i +: 8];
			@(posedge pclk);
		end
	endtask
	// One write on port B; callers keep port A off the address meanwhile.
	task automatic write(input logic [11:0] a, input logic [7:0] d);
		fpga_req <= '{we: 1'b1, addr: a, wdata: d};
		repeat (4) @(posedge pclk);
		fpga_clk <= 1'b1;
		repeat (4) @(posedge pclk);
		fpga_clk <= 1'b0;
		repeat (4) @(posedge pclk);
		fpga_req <= '{we: 1'b0, addr: a, wdata: ~d};
	endtask
	// Presents a read address; there is no read strobe to give.
	task automatic look(input logic [11:0] a);
		fpga_req <= '{we: 1'b0, addr: a, wdata: 8'hff};
	endtask
endmodule

// File: bench/test_config_ctrl_fpga_sram_port.sv
`timescale 1ns/1ps
module test_config_ctrl_fpga_sram_port
	import cfsp_pkg::*;
();
	localparam logic [63:0] W1 = 64'h8000000000000004;
	localparam logic [63:0] W2 = 64'h0000004000000018;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, init_pin, cfg_done_pin, check_pin_oe;
	logic cascade_select_out, cascade_select_oe, sram_port_clock_polarity, nv_byte_valid, fpga_clk, err;
	logic [7:0] paddr, nv_byte, cpu_rdata, fpga_rdata;
	logic [31:0] pwdata, prdata, rd;
	logic mode_lo, mode_hi;
	cfsp_cpu_req_t cpu_req;
	cfsp_sram_req_t fpga_req;
	int n_fail, comparisons;

	cfsp_top u_cfsp_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.cfg_mode_pin_low(mode_lo), .cfg_mode_pin_high(mode_hi), .nv_byte_valid(nv_byte_valid), .nv_byte(nv_byte),
		.init_pin(init_pin), .cfg_done_pin(cfg_done_pin), .check_pin_oe(check_pin_oe),
		.cascade_select_out(cascade_select_out), .cascade_select_oe(cascade_select_oe),
		.sram_port_clock_polarity(sram_port_clock_polarity), .cpu_req(cpu_req), .cpu_rdata(cpu_rdata),
		.fpga_clk(fpga_clk), .fpga_req(fpga_req), .fpga_rdata(fpga_rdata));
	cfsp_partner u_cfsp_partner (.pclk(pclk), .nv_byte_valid(nv_byte_valid), .nv_byte(nv_byte),
		.fpga_clk(fpga_clk), .fpga_req(fpga_req));

	// Free-running bus clock.
	always #5 pclk = ~pclk;

	// Compares one value and counts it.
	task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
		comparisons++;
		if (g !== e) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	// One bus transfer, held until the ready edge.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		chk("wait states", 2, n);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// One processor access; read data is settled two edges later.
	task automatic cpu(input logic b, input logic w, input logic [11:0] a, input logic [7:0] d);
		@(posedge pclk);
		cpu_req <= '{to_portb: b, req: '{we: w, addr: a, wdata: d}};
		@(posedge pclk);
		cpu_req.req.we <= 1'b0;
		repeat (2) @(posedge pclk);
	endtask
	// Reports counts and the verdict, then stops.
	task automatic conclude();
		$display("comparisons %0d n_fail %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// Watchdog against a hung handshake.
	initial begin
		#300000;
		n_fail++;
		conclude();
	end

	// Main sequence.
	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		cpu_req = '0;
		mode_lo = 1'b0;
		mode_hi = 1'b0;
		n_fail = 0;
		comparisons = 0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		repeat (4) @(posedge pclk);
		chk("check oe", 1'b1, check_pin_oe);
		chk("b rdata loading", 8'h00, fpga_rdata);
		u_cfsp_partner.load(W1);
		repeat (2) @(posedge pclk);
		chk("done", 1'b1, cfg_done_pin);
		apb(1'b0, 8'h00, 32'h0);
		chk("word lo", W1[31:0], rd);
		apb(1'b0, 8'h04, 32'h0);
		chk("word hi", W1[63:32], rd);
		apb(1'b0, 8'h10, 32'h0);
		chk("slverr", 1'b1, err);
		chk("clk pol", 1'b0, sram_port_clock_polarity);
		cpu(1'b0, 1'b1, 12'h801, 8'ha5);
		u_cfsp_partner.look(12'h801);
		cpu(1'b0, 1'b0, 12'h801, 8'h00);
		repeat (4) @(posedge pclk);
		chk("a rdata", 8'ha5, cpu_rdata);
		chk("b rdata", 8'ha5, fpga_rdata);
		u_cfsp_partner.write(12'h010, 8'h3c);
		cpu(1'b0, 1'b0, 12'h010, 8'h00);
		chk("b write", 8'h3c, cpu_rdata);
		apb(1'b1, 8'h08, 32'h1);
		u_cfsp_partner.write(12'h010, 8'hc3);
		cpu(1'b0, 1'b0, 12'h010, 8'h00);
		chk("gated write", 8'h3c, cpu_rdata);
		apb(1'b1, 8'h08, 32'h2);
		cpu(1'b1, 1'b1, 12'h020, 8'h5a);
		apb(1'b1, 8'h08, 32'h0);
		u_cfsp_partner.look(12'h020);
		repeat (6) @(posedge pclk);
		chk("debug route", 8'h5a, fpga_rdata);
		mode_lo <= 1'b1;
		apb(1'b1, 8'h08, 32'h4);
		repeat (3) @(posedge pclk);
		chk("cascade oe", 1'b0, cascade_select_oe);
		chk("check oe mode 1", 1'b1, check_pin_oe);
		chk("b off loading", 8'h00, fpga_rdata);
		fork
			u_cfsp_partner.load(W2);
			begin
				repeat (30) @(posedge pclk);
				chk("check released", 1'b0, check_pin_oe);
			end
		join
		repeat (2) @(posedge pclk);
		chk("lockout load done", 1'b1, cfg_done_pin);
		chk("clk pol set", 1'b1, sram_port_clock_polarity);
		u_cfsp_partner.write(12'h010, 8'h99);
		cpu(1'b0, 1'b0, 12'h010, 8'h00);
		chk("disabled write", 8'h3c, cpu_rdata);
		chk("b rdata off", 8'h00, fpga_rdata);
		apb(1'b1, 8'h00, 32'h0);
		apb(1'b0, 8'h00, 32'h0);
		chk("locked word", W2[31:0], rd);
		mode_hi <= 1'b1;
		apb(1'b1, 8'h08, 32'h4);
		repeat (2) @(posedge pclk);
		chk("reserved no start", 1'b1, cfg_done_pin);
		apb(1'b0, 8'h0c, 32'h0);
		chk("status", 32'h3e, rd);
		mode_hi <= 1'b0;
		apb(1'b1, 8'h08, 32'h4);
		repeat (4) @(posedge pclk);
		chk("init", 1'b1, init_pin);
		chk("done off", 1'b0, cfg_done_pin);
		conclude();
	end
endmodule
